// ==== hw/host_interface_pkg.sv ====
package host_interface_pkg;

	// ****************************************
	// register map, offsets are byte offsets
	// ****************************************
	localparam logic [3:0]  BANK_OFFSET     = 4'hF;
	localparam logic [1:0]  BANK_WORD       = BANK_OFFSET[3:2];
	localparam logic [1:0]  PTR_WORD        = 2'h1;
	localparam logic [1:0]  DATA_WORD       = 2'h2;
	localparam logic [2:0]  DATA_BANK       = 3'h2;
	localparam logic [2:0]  PHY_BANK        = 3'h7;
	localparam logic [3:0]  PHY_LIMIT       = 4'h8;
	localparam logic [7:0]  BANK_RESET      = 8'h00;
	localparam logic [31:0] PTR_RESET       = 32'h00000000;
	localparam int          PTR_READ_BIT    = 31;
	localparam int          ADDR_W          = 15;
	localparam int          RAM_ADDR_MSB    = 16;

	// ****************************************
	// timing
	// ****************************************
	localparam int          CLK_PERIOD_NS   = 8;
	localparam int          RAM_ACCESS_NS   = 25;
	localparam int          RAM_CYCLES      = (RAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0]  RAM_LAST        = 3'(RAM_CYCLES - 1);

	// ****************************************
	// states
	// ****************************************
	typedef enum logic [1:0] {CYC_IDLE, CYC_BUSY, CYC_DONE, CYC_SYNC_ACK} cyc_state_t;
	typedef enum logic [2:0] {SRC_NONE, SRC_CPU_WR, SRC_CPU_RD, SRC_TX, SRC_RX} ram_src_t;

endpackage

// ==== hw/host_interface_unit.sv ====
`timescale 1ns/10ps
module host_interface_unit #(
	parameter logic [11:0] IO_BASE = 12'h030
) (
	input  wire logic                                mclk_in,
	input  wire logic                                srst_in,
	input  wire logic [15:1]                         address_in,
	input  wire logic                                address_enable_in,
	input  wire logic [3:0]                          byte_enable_n_in,
	input  wire logic [31:0]                         data_in,
	output logic      [31:0]                         data_out,
	output logic                                     data_oe_out,
	input  wire logic                                address_strobe_n_in,
	input  wire logic                                read_strobe_n_in,
	input  wire logic                                write_strobe_n_in,
	input  wire logic                                cycle_start_n_in,
	input  wire logic                                local_bus_clock_in,
	input  wire logic                                write_not_read_in,
	input  wire logic                                data_path_select_n_in,
	input  wire logic                                local_bus_mode_n_in,
	output logic                                     async_cycle_ready_out,
	output logic                                     sync_cycle_ready_n_out,
	output logic                                     phy_select_out_n_out,
	output logic      [host_interface_pkg::RAM_ADDR_MSB:2] ram_addr_out,
	input  wire logic [31:0]                         ram_data_in,
	output logic      [31:0]                         ram_data_out,
	output logic                                     ram_data_oe_out,
	output logic      [3:0]                          ram_byte_write_n_out,
	output logic                                     ram_read_n_out,
	input  wire logic                                dma_tx_req_in,
	input  wire logic [host_interface_pkg::RAM_ADDR_MSB:2] dma_tx_addr_in,
	output logic                                     dma_tx_grant_out,
	output logic      [31:0]                         dma_tx_data_out,
	input  wire logic                                dma_rx_req_in,
	input  wire logic [host_interface_pkg::RAM_ADDR_MSB:2] dma_rx_addr_in,
	input  wire logic [31:0]                         dma_rx_data_in,
	input  wire logic [3:0]                          dma_rx_be_in,
	output logic                                     dma_rx_grant_out
);
	import host_interface_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	localparam int PINS = 9 + 15 + 4 + 32;
	logic [PINS-1:0] pin_meta;
	logic [PINS-1:0] pin_sync;
	logic            ads_n, rd_n, wr_n, cyc_n, local_bus_clock, w_nr, dp_n, vl_n, address_enable;
	logic [15:1]     addr_s;
	logic [3:0]      be_n_s;
	logic [31:0]     data_s;
	logic            local_bus_clock_prev, rd_prev, wr_prev;

	always_ff @(posedge mclk_in)
	begin
		pin_meta <= {address_strobe_n_in, read_strobe_n_in, write_strobe_n_in, cycle_start_n_in,
			local_bus_clock_in, write_not_read_in, data_path_select_n_in, local_bus_mode_n_in,
			address_enable_in, address_in, byte_enable_n_in, data_in};
		pin_sync <= pin_meta;
		local_bus_clock_prev <= local_bus_clock;
		rd_prev   <= rd_n;
		wr_prev   <= wr_n;
	end

	assign {ads_n, rd_n, wr_n, cyc_n, local_bus_clock, w_nr, dp_n, vl_n, address_enable, addr_s, be_n_s, data_s} = pin_sync;

	logic local_bus_clock_rise;
	logic strobe_fall;
	assign local_bus_clock_rise   = local_bus_clock && !local_bus_clock_prev;
	assign strobe_fall = (rd_prev && !rd_n) || (wr_prev && !wr_n);

	// ****************************************
	// address latch
	// ****************************************
	logic [15:1] lat_addr;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			lat_addr <= '0;
		else if (!ads_n && rd_n && wr_n)
			lat_addr <= addr_s;
	end

	latch_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		ads_n |=> $stable(lat_addr)) else $error("address latch moved while strobe high");

	// ****************************************
	// cycle control
	// ****************************************
	cyc_state_t  state;
	logic        cyc_write, cyc_sync, cyc_dp, cyc_hit, cyc_a1;
	logic [1:0]  cyc_word;
	logic [3:0]  cyc_be;
	logic [31:0] cyc_wdata;
	logic [7:0]  bank_sel;
	logic [31:0] ptr;
	logic        async_start, sync_start, burst_next, start;
	logic        decode_hit, target_data, can_finish, finish;

	assign async_start = (state == CYC_IDLE) && strobe_fall;
	assign sync_start  = (state == CYC_IDLE) && !vl_n && local_bus_clock_rise && !cyc_n;
	// a burst keeps the strobe low and moves one word per bus clock
	assign burst_next  = (state == CYC_DONE) && cyc_dp && vl_n && local_bus_clock_rise
		&& (!rd_n || !wr_n);
	assign start       = async_start || sync_start;
	assign decode_hit  = !address_enable && (lat_addr[15:4] == IO_BASE);
	assign target_data = cyc_dp || (cyc_hit && cyc_word == DATA_WORD
		&& bank_sel[2:0] == DATA_BANK);

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			cyc_write <= 1'b0;
			cyc_sync  <= 1'b0;
			cyc_dp    <= 1'b0;
			cyc_hit   <= 1'b0;
			cyc_a1    <= 1'b0;
			cyc_word  <= '0;
			cyc_be    <= '0;
			cyc_wdata <= '0;
		end
		else if (start || burst_next)
		begin
			cyc_write <= sync_start ? w_nr : !wr_n;
			cyc_sync  <= sync_start;
			cyc_dp    <= !dp_n;
			cyc_hit   <= decode_hit || !dp_n;
			cyc_a1    <= dp_n && lat_addr[1];
			cyc_word  <= lat_addr[3:2];
			// no byte lane swapping, only the halves move with address bit 1
			cyc_be    <= (dp_n && lat_addr[1]) ? {~be_n_s[1:0], ~be_n_s[3:2]} : ~be_n_s;
			cyc_wdata <= (dp_n && lat_addr[1]) ? {data_s[15:0], data_s[31:16]} : data_s;
		end
	end

	dp_bypass_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(start && !dp_n) |=> (cyc_dp && target_data)) else $error("path select did not bypass decode");

	// ****************************************
	// data path buffers
	// ****************************************
	logic        wbuf_ready, wbuf_valid, wbuf_pop;
	logic [50:0] wbuf_out;
	logic        rbuf_push, rbuf_ready, rbuf_valid, rbuf_pop, rbuf_flush;
	logic [31:0] rbuf_out;
	logic [31:0] ram_rdata;
	logic [2:0]  byte_count, lane_sum;
	logic [4:0]  lane_shift;
	logic        wbuf_push;
	logic        ptr_read;

	assign byte_count = 3'(cyc_be[0]) + 3'(cyc_be[1]) + 3'(cyc_be[2]) + 3'(cyc_be[3]);
	assign lane_sum   = {1'b0, ptr[1:0]} + byte_count;
	assign lane_shift = {ptr[1:0], 3'b000};
	assign ptr_read   = ptr[PTR_READ_BIT];
	// a read needs a word already in the read buffer, a write needs room in the write buffer, else the bus waits
	assign can_finish = !target_data || (cyc_write ? wbuf_ready : rbuf_valid);
	assign finish     = (state == CYC_BUSY) && can_finish;
	assign wbuf_push  = finish && target_data && cyc_write;
	assign rbuf_pop   = finish && target_data && !cyc_write && lane_sum[2];

	two_entry_buffer #(.WIDTH(51), .DEPTH(2)) write_buffer (
		.mclk_in       (mclk_in),
		.srst_in       (srst_in),
		.flush_in      (1'b0),
		.in_valid_in   (wbuf_push),
		.in_ready_out  (wbuf_ready),
		.in_data_in    ({ptr[RAM_ADDR_MSB:2],
			4'((cyc_be << ptr[1:0]) | (cyc_be >> (3'd4 - lane_sum + byte_count))),
			32'((cyc_wdata << lane_shift) | (cyc_wdata >> (6'd32 - 6'(lane_shift))))}),
		.out_valid_out (wbuf_valid),
		.out_ready_in  (wbuf_pop),
		.out_data_out  (wbuf_out)
	);

	two_entry_buffer #(.WIDTH(32), .DEPTH(2)) read_buffer (
		.mclk_in       (mclk_in),
		.srst_in       (srst_in),
		.flush_in      (rbuf_flush),
		.in_valid_in   (rbuf_push),
		.in_ready_out  (rbuf_ready),
		.in_data_in    (ram_rdata),
		.out_valid_out (rbuf_valid),
		.out_ready_in  (rbuf_pop),
		.out_data_out  (rbuf_out)
	);

	// ****************************************
	// registers
	// ****************************************
	logic        reg_wr;
	logic [31:0] read_word;
	logic [31:0] next_ptr;

	assign reg_wr = finish && cyc_write && cyc_hit && !cyc_dp;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			bank_sel <= BANK_RESET;
		else if (reg_wr && cyc_word == BANK_WORD && cyc_be[3])
			bank_sel <= cyc_wdata[31:24];
	end

	always_comb
	begin
		next_ptr = ptr;
		if (reg_wr && cyc_word == PTR_WORD && bank_sel[2:0] == DATA_BANK)
		begin
			for (int i = 0; i < 4; i++)
				if (cyc_be[i])
					next_ptr[i*8 +: 8] = cyc_wdata[i*8 +: 8];
		end
		else if (finish && target_data)
			next_ptr[RAM_ADDR_MSB:0] = ptr[RAM_ADDR_MSB:0] + 17'(byte_count);
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			ptr <= PTR_RESET;
		else
			ptr <= next_ptr;
	end

	assign rbuf_flush = reg_wr && cyc_word == PTR_WORD && bank_sel[2:0] == DATA_BANK;

	always_comb
	begin
		read_word = '0;
		if (target_data)
			read_word = (rbuf_out >> lane_shift) | (rbuf_out << (6'd32 - 6'(lane_shift)));
		else if (cyc_word == BANK_WORD)
			read_word = {bank_sel, 24'h000000};
		else if (cyc_word == PTR_WORD && bank_sel[2:0] == DATA_BANK)
			read_word = ptr;
	end

	bank_dword_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(reg_wr && cyc_word == BANK_WORD && cyc_be == 4'hF)
		|=> (bank_sel == $past(cyc_wdata[31:24])) && $stable(ptr))
		else $error("dword write at Ch touched more than the bank register");

	// ****************************************
	// bus handshake
	// ****************************************
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			state <= CYC_IDLE;
		else
			unique case (state)
				CYC_IDLE:
					if (start)
						state <= CYC_BUSY;
				CYC_BUSY:
					if (finish)
						state <= CYC_DONE;
				CYC_DONE:
					if (cyc_sync && local_bus_clock_rise)
						state <= CYC_SYNC_ACK;
					else if (burst_next)
						state <= CYC_BUSY;
					else if (!cyc_sync && rd_n && wr_n)
						state <= CYC_IDLE;
				CYC_SYNC_ACK:
					if (local_bus_clock_rise)
						state <= CYC_IDLE;
			endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			async_cycle_ready_out <= 1'b1;
		else if (async_start || burst_next)
			async_cycle_ready_out <= 1'b0;
		else if (finish)
			async_cycle_ready_out <= 1'b1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			sync_cycle_ready_n_out <= 1'b1;
		else if (local_bus_clock_rise)
			sync_cycle_ready_n_out <= !(state == CYC_DONE && cyc_sync);
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			data_out    <= '0;
			data_oe_out <= 1'b0;
		end
		else if (finish && !cyc_write)
		begin
			data_out    <= cyc_a1 ? {read_word[15:0], read_word[31:16]} : read_word;
			data_oe_out <= cyc_hit;
		end
		else if (state == CYC_IDLE)
			data_oe_out <= 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			phy_select_out_n_out <= 1'b1;
		else
			phy_select_out_n_out <= !(decode_hit && dp_n && bank_sel[2:0] == PHY_BANK
				&& {lat_addr[3:1], 1'b0} < PHY_LIMIT && (!rd_n || !wr_n));
	end

	async_ready_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		async_start |=> !async_cycle_ready_out) else $error("ready not dropped on strobe edge");
	not_ready_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(state == CYC_BUSY && !can_finish) |=> (state == CYC_BUSY)
		&& (cyc_sync || !async_cycle_ready_out))
		else $error("cycle completed without buffer room");
	sync_ready_clk_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		!$stable(sync_cycle_ready_n_out) |-> $past(local_bus_clock_rise)) else $error("sync ready off bus clock");
	phy_select_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		!phy_select_out_n_out |-> $past(bank_sel[2:0]) == PHY_BANK && !$past(lat_addr[3]))
		else $error("phy select outside bank seven low range");
	word_swap_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(start && dp_n && lat_addr[1] && !wr_n)
		|=> cyc_wdata == {$past(data_s[15:0]), $past(data_s[31:16])})
		else $error("halves not swapped for address bit 1");

	// ****************************************
	// packet ram arbiter
	// ****************************************
	ram_src_t arb_src, pick;
	logic [2:0] arb_cnt;
	logic       last_tx;
	logic       pf_req, pf_live;
	logic [RAM_ADDR_MSB:2] pf_addr;

	assign pf_req = ptr_read && rbuf_ready && !rbuf_flush && !rbuf_valid;

	always_comb
	begin
		pick = SRC_NONE;
		if (wbuf_valid)
			pick = SRC_CPU_WR;
		else if (pf_req)
			pick = SRC_CPU_RD;
		else if (dma_tx_req_in && dma_rx_req_in)
			pick = last_tx ? SRC_RX : SRC_TX;
		else if (dma_tx_req_in)
			pick = SRC_TX;
		else if (dma_rx_req_in)
			pick = SRC_RX;
	end

	assign wbuf_pop  = (arb_src == SRC_CPU_WR) && (arb_cnt == RAM_LAST);
	assign rbuf_push = (arb_src == SRC_CPU_RD) && (arb_cnt == RAM_LAST) && pf_live;
	assign ram_rdata = ram_data_in;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			arb_src <= SRC_NONE;
			arb_cnt <= '0;
			last_tx <= 1'b0;
		end
		else if (arb_src == SRC_NONE)
		begin
			arb_src <= pick;
			arb_cnt <= '0;
			if (pick == SRC_TX || pick == SRC_RX)
				last_tx <= (pick == SRC_TX);
		end
		else if (arb_cnt == RAM_LAST)
			arb_src <= SRC_NONE;
		else
			arb_cnt <= arb_cnt + 3'd1;
	end

	// a pointer rewrite while a fetch is in flight makes that word stale
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			pf_addr <= '0;
			pf_live <= 1'b0;
		end
		else if (rbuf_flush)
		begin
			pf_addr <= next_ptr[RAM_ADDR_MSB:2];
			pf_live <= 1'b0;
		end
		else if (arb_src == SRC_NONE && pick == SRC_CPU_RD)
			pf_live <= 1'b1;
		else if (rbuf_push)
			pf_addr <= pf_addr + 15'd1;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			ram_addr_out         <= '0;
			ram_data_out         <= '0;
			ram_data_oe_out      <= 1'b0;
			ram_byte_write_n_out <= 4'hF;
			ram_read_n_out       <= 1'b1;
		end
		else if (arb_src == SRC_NONE)
		begin
			ram_byte_write_n_out <= 4'hF;
			ram_read_n_out       <= 1'b1;
			ram_data_oe_out      <= 1'b0;
			unique case (pick)
				SRC_CPU_WR:
				begin
					ram_addr_out         <= wbuf_out[50:36];
					ram_data_out         <= wbuf_out[31:0];
					ram_data_oe_out      <= 1'b1;
					ram_byte_write_n_out <= ~wbuf_out[35:32];
				end
				SRC_RX:
				begin
					ram_addr_out         <= dma_rx_addr_in;
					ram_data_out         <= dma_rx_data_in;
					ram_data_oe_out      <= 1'b1;
					ram_byte_write_n_out <= ~dma_rx_be_in;
				end
				SRC_CPU_RD:
				begin
					ram_addr_out   <= pf_addr;
					ram_read_n_out <= 1'b0;
				end
				SRC_TX:
				begin
					ram_addr_out   <= dma_tx_addr_in;
					ram_read_n_out <= 1'b0;
				end
				SRC_NONE:
					ram_read_n_out <= 1'b1;
			endcase
		end
		else if (arb_cnt == RAM_LAST)
		begin
			ram_byte_write_n_out <= 4'hF;
			ram_read_n_out       <= 1'b1;
			ram_data_oe_out      <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			dma_tx_grant_out <= 1'b0;
			dma_rx_grant_out <= 1'b0;
			dma_tx_data_out  <= '0;
		end
		else
		begin
			dma_tx_grant_out <= (arb_src == SRC_TX) && (arb_cnt == RAM_LAST);
			dma_rx_grant_out <= (arb_src == SRC_RX) && (arb_cnt == RAM_LAST);
			if ((arb_src == SRC_TX) && (arb_cnt == RAM_LAST))
				dma_tx_data_out <= ram_data_in;
		end
	end

	alternate_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(arb_src == SRC_NONE && dma_tx_req_in && dma_rx_req_in && !wbuf_valid && !pf_req)
		|=> arb_src == ($past(last_tx) ? SRC_RX : SRC_TX)) else $error("dma sides not alternated");
	ram_write_src_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(ram_byte_write_n_out != 4'hF) |-> (arb_src == SRC_CPU_WR || arb_src == SRC_RX)
		&& ram_read_n_out) else $error("ram write enable without writer");
	ram_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
		(arb_src == SRC_NONE && pick != SRC_NONE) |=> (arb_src != SRC_NONE) [*3])
		else $error("ram access shorter than access time");
endmodule

// ==== hw/two_entry_buffer.sv ====
`timescale 1ns/10ps
module two_entry_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input  wire logic             mclk_in,
	input  wire logic             srst_in,
	input  wire logic             flush_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign in_ready_out  = (count != (PW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out  = store[rd_ptr];

	always_ff @(posedge mclk_in)
	begin
		if (push)
			store[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in || flush_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ==== test/host_cpu_model.sv ====
`timescale 1ns/10ps
module host_cpu_model (
	input  wire logic        mclk_in,
	input  wire logic [31:0] data_out,
	input  wire logic        async_cycle_ready_out,
	input  wire logic        sync_cycle_ready_n_out,
	output logic      [15:1] address_in,
	output logic             address_enable_in,
	output logic      [3:0]  byte_enable_n_in,
	output logic      [31:0] data_in,
	output logic             address_strobe_n_in,
	output logic             read_strobe_n_in,
	output logic             write_strobe_n_in,
	output logic             cycle_start_n_in,
	output logic             local_bus_clock_in,
	output logic             write_not_read_in,
	output logic             data_path_select_n_in,
	output logic             local_bus_mode_n_in
);
	logic local_bus_clock_run = 1'b0;
	initial
	begin
		{address_strobe_n_in, read_strobe_n_in, write_strobe_n_in, cycle_start_n_in,
			data_path_select_n_in, local_bus_mode_n_in, byte_enable_n_in} = '1;
		{address_in, address_enable_in, data_in, local_bus_clock_in, write_not_read_in} = '0;
	end
	// bus clock only runs inside synchronous frames and path select bursts
	always
	begin
		#80;
		if (local_bus_clock_run)
			local_bus_clock_in = ~local_bus_clock_in;
	end
	// ****************************************
	// strobe cycle, optionally through path select
	// ****************************************
	task automatic cyc(input logic we, sel, address_enable, input logic [15:1] a, input logic [3:0] be,
			input logic [31:0] wd, output logic [31:0] rd, output logic ok);
		ok = 1'b0;
		rd = '0;
		@(posedge mclk_in);
		#1;
		address_in = a;
		address_enable_in = address_enable;
		byte_enable_n_in = sel ? 4'h0 : be;
		data_path_select_n_in = ~sel;
		data_in = wd;
		address_strobe_n_in = 1'b0;
		@(posedge mclk_in);
		#1;
		address_strobe_n_in = 1'b1;
		write_strobe_n_in = ~we;
		read_strobe_n_in = we;
		repeat (4) @(posedge mclk_in);
		#1;
		address_in = ~a;
		for (int i = 0; i < 60 && !ok; i++)
		begin
			@(posedge mclk_in);
			ok = (async_cycle_ready_out === 1'b1);
			rd = data_out;
		end
		#1;
		{write_strobe_n_in, read_strobe_n_in, data_path_select_n_in, byte_enable_n_in} = '1;
		data_in = ~wd;
		repeat (4) @(posedge mclk_in);
	endtask
	// read and write strobes stay high for the whole frame, so the two kinds never overlap
	task automatic scyc(input logic [15:1] a, input logic [3:0] be, input logic [31:0] wd,
			output int lo);
		lo = 0;
		local_bus_clock_run = 1'b1;
		@(negedge local_bus_clock_in);
		#1;
		address_in = a;
		byte_enable_n_in = be;
		data_in = wd;
		write_not_read_in = 1'b1;
		address_enable_in = 1'b0;
		{local_bus_mode_n_in, address_strobe_n_in, cycle_start_n_in} = '0;
		@(negedge local_bus_clock_in);
		#1;
		cycle_start_n_in = 1'b1;
		for (int i = 0; i < 400 && lo == 0; i++)
		begin
			@(posedge mclk_in);
			lo = (sync_cycle_ready_n_out === 1'b0);
		end
		#1;
		{local_bus_mode_n_in, address_strobe_n_in} = '1;
		data_in = ~wd;
		for (int i = 0; i < 400 && lo > 0; i++)
		begin
			@(posedge mclk_in);
			if (sync_cycle_ready_n_out !== 1'b0)
				break;
			lo++;
		end
		local_bus_clock_run = 1'b0;
	endtask
	// path select burst: the strobe takes the first word, the next bus clock rise the second
	task automatic burst(input logic [31:0] wd0, wd1);
		local_bus_clock_run = 1'b1;
		@(negedge local_bus_clock_in);
		#1;
		{data_path_select_n_in, byte_enable_n_in} = '0;
		data_in = wd0;
		write_strobe_n_in = 1'b0;
		repeat (6) @(posedge mclk_in);
		#1;
		data_in = wd1;
		@(negedge local_bus_clock_in);
		#1;
		{write_strobe_n_in, data_path_select_n_in, byte_enable_n_in} = '1;
		local_bus_clock_run = 1'b0;
		repeat (8) @(posedge mclk_in);
	endtask
endmodule

// ==== test/host_interface_unit_bench.sv ====
`timescale 1ns/10ps
module host_interface_unit_bench;
	import host_interface_pkg::*;
	logic        mclk_in = 1'b0;
	logic        srst_in, address_enable_in, data_oe_out, address_strobe_n_in, read_strobe_n_in,
		write_strobe_n_in, cycle_start_n_in, local_bus_clock_in, write_not_read_in,
		data_path_select_n_in, local_bus_mode_n_in, async_cycle_ready_out, sync_cycle_ready_n_out,
		phy_select_out_n_out, ram_data_oe_out, ram_read_n_out, dma_tx_req_in, dma_tx_grant_out,
		dma_rx_req_in, dma_rx_grant_out, phy_seen;
	logic [15:1] address_in;
	logic [31:0] data_in, data_out, ram_data_in, ram_data_out, dma_tx_data_out, dma_rx_data_in, rd;
	logic [3:0]  byte_enable_n_in, ram_byte_write_n_out, dma_rx_be_in;
	logic [RAM_ADDR_MSB:2] ram_addr_out, dma_tx_addr_in, dma_rx_addr_in;
	logic [31:0] mem [8];
	int          bad_count = 0;
	int          check_count = 0;
	int          lo;
	host_interface_unit #(.IO_BASE(12'h030)) dut (.mclk_in, .srst_in, .address_in,
		.address_enable_in, .byte_enable_n_in, .data_in, .data_out, .data_oe_out,
		.address_strobe_n_in, .read_strobe_n_in, .write_strobe_n_in, .cycle_start_n_in,
		.local_bus_clock_in, .write_not_read_in, .data_path_select_n_in, .local_bus_mode_n_in,
		.async_cycle_ready_out, .sync_cycle_ready_n_out, .phy_select_out_n_out, .ram_addr_out,
		.ram_data_in, .ram_data_out, .ram_data_oe_out, .ram_byte_write_n_out, .ram_read_n_out,
		.dma_tx_req_in, .dma_tx_addr_in, .dma_tx_grant_out, .dma_tx_data_out, .dma_rx_req_in,
		.dma_rx_addr_in, .dma_rx_data_in, .dma_rx_be_in, .dma_rx_grant_out);
	host_cpu_model host (.mclk_in, .data_out, .async_cycle_ready_out, .sync_cycle_ready_n_out,
		.address_in, .address_enable_in, .byte_enable_n_in, .data_in, .address_strobe_n_in,
		.read_strobe_n_in, .write_strobe_n_in, .cycle_start_n_in, .local_bus_clock_in,
		.write_not_read_in, .data_path_select_n_in, .local_bus_mode_n_in);
	// ****************************************
	// packet ram, shows the inverted addressed word while not read
	// ****************************************
	assign ram_data_in = ram_read_n_out ? ~mem[ram_addr_out[4:2]] : mem[ram_addr_out[4:2]];
	always @(posedge mclk_in)
	begin
		for (int b = 0; b < 4; b++)
			if (ram_byte_write_n_out[b] === 1'b0)
				mem[ram_addr_out[4:2]][8*b+:8] <= ram_data_out[8*b+:8];
		if (phy_select_out_n_out === 1'b0)
			phy_seen <= 1'b1;
	end
	initial
		forever #4 mclk_in = ~mclk_in;
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic acc(input logic we, sel, address_enable, input logic [3:0] w, be, input logic [31:0] wd);
		logic ok;
		host.cyc(we, sel, address_enable, {12'h030, w[3:1]}, be, wd, rd, ok);
		if (!ok)
		begin
			bad_count++;
			end_sim();
		end
	endtask
	task automatic wait_mem(input int i, input logic [31:0] v);
		for (int n = 0; n < 200 && mem[i] !== v; n++)
			@(posedge mclk_in);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_bank;
		chk({async_cycle_ready_out, sync_cycle_ready_n_out, phy_select_out_n_out, ram_read_n_out,
			data_oe_out, ram_data_oe_out, dma_tx_grant_out, dma_rx_grant_out}, 8'hF0);
		chk(ram_byte_write_n_out, 4'hF);
		acc(0, 0, 0, 4'hC, 4'h7, '0);
		chk(rd[31:24], BANK_RESET);
		acc(1, 0, 0, 4'hC, 4'h7, 32'h03000000);
		acc(1, 0, 1, 4'hC, 4'h7, 32'h07000000);
		acc(0, 0, 0, 4'hC, 4'h7, '0);
		chk(rd[31:24], 8'h03);
		acc(1, 0, 0, 4'hC, 4'h0, 32'h05AABBCC);
		acc(0, 0, 0, 4'hC, 4'h7, '0);
		chk(rd[31:24], 8'h05);
		acc(1, 0, 0, 4'hE, 4'hD, 32'h00000600);
		acc(0, 0, 0, 4'hC, 4'h7, '0);
		chk(rd[31:24], 8'h06);
		acc(0, 0, 0, 4'hE, 4'hD, '0);
		chk(rd[15:8], 8'h06);
	endtask
	task automatic t_phy;
		acc(1, 0, 0, 4'hC, 4'h7, {5'h0, PHY_BANK, 24'h0});
		phy_seen = 1'b0;
		acc(0, 0, 0, 4'h0, 4'h0, '0);
		chk(phy_seen, 1'b1);
		phy_seen = 1'b0;
		acc(0, 0, 0, 4'h8, 4'h0, '0);
		acc(1, 0, 0, 4'hC, 4'h7, {5'h0, DATA_BANK, 24'h0});
		acc(0, 0, 0, 4'h0, 4'h0, '0);
		chk(phy_seen, 1'b0);
	endtask
	task automatic t_path;
		acc(1, 0, 0, 4'h4, 4'h0, PTR_RESET);
		acc(1, 1, 1, 4'h0, 4'h0, 32'hA5A50001);
		acc(1, 1, 1, 4'h0, 4'h0, 32'h01020304);
		wait_mem(1, 32'h01020304);
		chk(mem[0], 32'hA5A50001);
		chk(mem[1], 32'h01020304);
		acc(1, 0, 0, 4'h4, 4'h0, 32'h8);
		acc(1, 0, 0, 4'h8, 4'hE, 32'h000000EE);
		wait_mem(2, 32'hEE);
		chk(mem[2], 32'h000000EE);
		acc(1, 0, 0, 4'h4, 4'h0, 32'h80000000);
		acc(0, 1, 1, 4'h0, 4'h0, '0);
		chk(rd, 32'hA5A50001);
		acc(0, 1, 1, 4'h0, 4'h0, '0);
		chk(rd, 32'h01020304);
		acc(1, 0, 0, 4'h4, 4'h0, 32'h10);
		host.burst(32'h11112222, 32'h33334444);
		wait_mem(5, 32'h33334444);
		chk(mem[4], 32'h11112222);
		chk(mem[5], 32'h33334444);
	endtask
	task automatic t_sync;
		host.scyc({12'h030, 3'h6}, 4'h7, 32'h04000000, lo);
		chk(lo, 20);
		acc(0, 0, 0, 4'hC, 4'h7, '0);
		chk(rd[31:24], 8'h04);
	endtask
	task automatic t_dma;
		int   n;
		logic last;
		n = 0;
		last = 1'b0;
		mem[5] = 32'h600DF00D;
		@(posedge mclk_in);
		#1;
		{dma_tx_req_in, dma_rx_req_in} = 2'b11;
		for (int i = 0; i < 400 && n < 4; i++)
		begin
			@(posedge mclk_in);
			if (dma_tx_grant_out === 1'b1 || dma_rx_grant_out === 1'b1)
			begin
				if (n > 0)
					chk(dma_tx_grant_out, !last);
				if (dma_tx_grant_out === 1'b1)
					chk(dma_tx_data_out, 32'h600DF00D);
				last = dma_tx_grant_out;
				n++;
			end
		end
		#1;
		{dma_tx_req_in, dma_rx_req_in} = 2'b00;
		chk(n, 4);
		chk(mem[6], 32'hCAFE1234);
	endtask
	initial
	begin
		srst_in = 1'b1;
		phy_seen = 1'b0;
		{dma_tx_req_in, dma_rx_req_in} = 2'b00;
		dma_tx_addr_in = 15'h5;
		dma_rx_addr_in = 15'h6;
		dma_rx_data_in = 32'hCAFE1234;
		dma_rx_be_in = 4'hF;
		for (int i = 0; i < 8; i++)
			mem[i] = '0;
		repeat (12) @(posedge mclk_in);
		#1;
		srst_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		t_bank();
		t_phy();
		t_path();
		t_sync();
		t_dma();
		end_sim();
	end
endmodule
